// [sdc_cfg.svh]
// Constants for the synchronous DRAM command decoder
// Assumes a 200 MHz ref_clk_in; included by the core module only
`ifndef SDC_CFG_SVH
`define SDC_CFG_SVH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define SDC_NUM_ROWS      8192
`define SDC_COLS_X4       2048
`define SDC_COLS_X8       1024
`define SDC_COLS_X16      512
`define SDC_ORG_X4        2'h0
`define SDC_ORG_X8        2'h1
`define SDC_ORG_X16       2'h2

// ----------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------
`define SDC_AP_BIT        10
`define SDC_COL_HI_BIT    11
`define SDC_BL_LSB        0
`define SDC_BL_MSB        2
`define SDC_SEQ_BIT       3
`define SDC_CL_LSB        4
`define SDC_CL_MSB        6
`define SDC_MODE_RESET    12'h000
`define SDC_BL_PAGE       3'h7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SDC_CLK_PERIOD_PS 5000
`define SDC_WR_EXTRA_PS   7500
`define SDC_PRE_WAIT_PS   20000
`define SDC_WR_EXTRA_CYC  (((`SDC_WR_EXTRA_PS) + (`SDC_CLK_PERIOD_PS) - 1) / (`SDC_CLK_PERIOD_PS))
`define SDC_PRE_WAIT_CYC  (((`SDC_PRE_WAIT_PS) + (`SDC_CLK_PERIOD_PS) - 1) / (`SDC_CLK_PERIOD_PS))
`define SDC_DQM_RD_LAT    2

`endif

// [sdc_command_access_tb.sv]
// Self-checking bench for sdc_core with controller and array models
// Assumes the checker binds itself; run ends through end_sim
`timescale 1ns/10ps
module sdc_command_access_tb;
  logic        ref_clk_in;
  logic        rst_in;
  logic [3:0]  cmd;
  logic        cke;
  logic [1:0]  bank;
  logic [12:0] addr;
  logic [1:0]  dqm;
  logic [15:0] dq_wr;
  logic [1:0]  org;
  logic [15:0] dq_rd;
  logic [1:0]  dq_oe;
  logic        a_valid;
  logic        a_write;
  logic [1:0]  a_bank;
  logic [12:0] a_row;
  logic [10:0] a_col;
  logic [1:0]  a_mask;
  logic [15:0] a_wd;
  logic        a_ready;
  logic [15:0] a_rdata;
  logic [3:0]  bank_open;
  logic [11:0] mode;
  logic        self_ref;
  logic        cmd_rdy;
  logic        stall;
  int          n_errors;
  int          check_count;
  logic [44:0] wq[$];
  logic [17:0] rq[$];
  logic [10:0] cols[3] = '{11'h605, 11'h205, 11'h005};

  sdc_ctrl_model #(.PAUSE_CYC(20)) i_sdc_ctrl_model (
    .ref_clk_in (ref_clk_in), .cmd_out (cmd), .cke_out (cke), .bank_out (bank),
    .addr_out (addr), .dqm_out (dqm), .dq_out (dq_wr));

  sdc_core i_sdc_core (
    .ref_clk_in (ref_clk_in), .rst_in (rst_in), .cs_n_in (cmd[3]), .ras_n_in (cmd[2]),
    .cas_n_in (cmd[1]), .we_n_in (cmd[0]), .cke_in (cke), .bank_select_lo_in (bank[0]),
    .bank_select_hi_in (bank[1]), .addr_in (addr), .dqm_in (dqm), .dq_in (dq_wr),
    .org_in (org), .dq_out (dq_rd), .dq_oe_out (dq_oe), .arr_valid_out (a_valid),
    .arr_write_out (a_write), .arr_bank_out (a_bank), .arr_row_out (a_row),
    .arr_col_out (a_col), .arr_mask_out (a_mask), .arr_wdata_out (a_wd),
    .arr_ready_in (a_ready), .arr_rdata_in (a_rdata), .bank_open_out (bank_open),
    .mode_out (mode), .self_refresh_out (self_ref), .cmd_ready_out (cmd_rdy));

  // Clock at 200 MHz
  initial
  begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end

  // Array model: takes the head word unless stalled, answers reads next cycle
  always @(posedge ref_clk_in)
  begin
    a_ready <= !stall;
    if (a_valid && a_ready)
    begin
      wq.push_back({a_write, a_bank, a_row, a_col, a_mask, a_wd});
      a_rdata <= {8'h5a, a_col[7:0]};
    end
    else
      a_rdata <= ~a_rdata;
    if (dq_oe != 2'h0)
      rq.push_back({dq_oe, dq_rd});
  end

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic op(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
    i_sdc_ctrl_model.cmd(c, b, a, 2'h0, 16'h0000, 16'hffff);
  endtask : op

  task automatic wr(input logic [1:0] b, input logic [12:0] a, input logic [1:0] m,
                    input logic [15:0] d, input logic [15:0] d2);
    i_sdc_ctrl_model.cmd(4'h4, b, a, m, d, d2);
  endtask : wr

  task automatic rd(input logic [1:0] b, input logic [12:0] a, input logic [1:0] m);
    i_sdc_ctrl_model.cmd(4'h5, b, a, m, 16'h0000, 16'hffff);
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : settle

  task automatic wait_q(input int n);
    for (int i = 0; (i < 60) && (wq.size() < n); i++)
      @(posedge ref_clk_in);
    #1;
  endtask : wait_q

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if ((n_errors == 0) && (check_count > 0))
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  // Watchdog well beyond the expected run
  initial
  begin
    #20000;
    n_errors++;
    end_sim();
  end

  // Main sequence
  initial
  begin
    rst_in = 1'b1;
    stall = 1'b0;
    org = 2'h2;
    a_ready = 1'b0;
    a_rdata = 16'h0000;
    n_errors = 0;
    check_count = 0;
    settle(6);
    chk("reset outputs", 64'h0, {bank_open, mode, a_valid, dq_oe, self_ref});
    @(posedge ref_clk_in);
    rst_in <= 1'b0;
    i_sdc_ctrl_model.init();
    op(4'h0, 2'h3, 13'h1001);
    settle(2);
    chk("mode", 12'h001, mode);
    op(4'h3, 2'h2, 13'h1abc);
    op(4'hb, 2'h1, 13'h0005);
    op(4'h7, 2'h3, 13'h0006);
    settle(2);
    chk("open banks", 4'h4, bank_open);
    stall = 1'b1;
    wq.delete();
    wr(2'h2, 13'h0205, 2'h1, 16'h1234, 16'h5678);
    settle(4);
    chk("words while stalled", 0, wq.size());
    stall = 1'b0;
    wait_q(2);
    chk("write beat 0", {1'b1, 2'h2, 13'h1abc, 11'h005, 2'h1, 16'h1234}, wq[0]);
    chk("write beat 1", {1'b1, 2'h2, 13'h1abc, 11'h004, 2'h1, 16'h5678}, wq[1]);
    chk("row kept open", 4'h4, bank_open);
    rq.delete();
    rd(2'h2, 13'h0408, 2'h2);
    settle(16);
    chk("read beats", 2, rq.size());
    chk("read beat 0", {2'h1, 8'h08}, {rq[0][17:16], rq[0][7:0]});
    chk("read beat 1", {2'h1, 8'h09}, {rq[1][17:16], rq[1][7:0]});
    chk("auto precharge", 4'h0, bank_open);
    op(4'h3, 2'h0, 13'h0011);
    op(4'h3, 2'h1, 13'h0022);
    op(4'h2, 2'h0, 13'h1bff);
    settle(2);
    chk("one bank precharged", 4'h2, bank_open);
    op(4'h2, 2'h0, 13'h0400);
    op(4'h1, 2'h3, 13'h1fff);
    settle(2);
    chk("after refresh", 6'h01, {bank_open, self_ref, cmd_rdy});
    i_sdc_ctrl_model.set_cke(1'b0);
    op(4'h1, 2'h0, 13'h0000);
    op(4'h3, 2'h3, 13'h0033);
    settle(2);
    chk("in self refresh", 5'h01, {bank_open, self_ref});
    i_sdc_ctrl_model.set_cke(1'b1);
    settle(8);
    chk("self refresh left", 1'b0, self_ref);
    op(4'h0, 2'h0, 13'h0000);
    op(4'h3, 2'h0, 13'h0001);
    for (int k = 0; k < 3; k++)
    begin
      @(posedge ref_clk_in);
      org <= 2'(k);
      wq.delete();
      wr(2'h0, 13'h0a05, 2'h0, 16'(16'h00a0 + k), 16'hffff);
      wait_q(1);
      chk("column", {1'b1, 2'h0, 13'h0001, cols[k], 2'h0, 16'(16'h00a0 + k)}, wq[0]);
    end
    op(4'h2, 2'h0, 13'h0400);
    op(4'h0, 2'h0, 13'h0003);
    op(4'h3, 2'h1, 13'h0077);
    wq.delete();
    wr(2'h1, 13'h0000, 2'h0, 16'h0f0f, 16'hf0f0);
    op(4'h6, 2'h0, 13'h0000);
    settle(12);
    chk("terminated burst", 1'b1, (wq.size() >= 1) && (wq.size() < 8));
    end_sim();
  end
endmodule : sdc_command_access_tb

// [sdc_core.sv]
// Command decoder, bank tracker and burst engine of a four-bank SDRAM
// Pins arrive from another domain and pass two flops; array is external
`timescale 1ns/10ps
`include "sdc_cfg.svh"

module sdc_core (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  // Command pins
  input  wire logic        cs_n_in,
  input  wire logic        ras_n_in,
  input  wire logic        cas_n_in,
  input  wire logic        we_n_in,
  input  wire logic        cke_in,
  input  wire logic        bank_select_lo_in,
  input  wire logic        bank_select_hi_in,
  input  wire logic [12:0] addr_in,
  input  wire logic [1:0]  dqm_in,
  input  wire logic [15:0] dq_in,
  input  wire logic [1:0]  org_in,
  // Data pin drive
  output logic      [15:0] dq_out,
  output logic      [1:0]  dq_oe_out,
  // Array side: write/read requests through the two-entry buffer
  output logic             arr_valid_out,
  output logic             arr_write_out,
  output logic      [1:0]  arr_bank_out,
  output logic      [12:0] arr_row_out,
  output logic      [10:0] arr_col_out,
  output logic      [1:0]  arr_mask_out,
  output logic      [15:0] arr_wdata_out,
  input  wire logic        arr_ready_in,
  input  wire logic [15:0] arr_rdata_in,
  // Status
  output logic      [3:0]  bank_open_out,
  output logic      [11:0] mode_out,
  output logic             self_refresh_out,
  output logic             cmd_ready_out
);

  sdc_pkg::sdc_state_t st_ff;
  sdc_pkg::sdc_state_t nxt_st;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Strobe decode of the second-stage pins
  function automatic sdc_pkg::sdc_cmd_t decode(input sdc_pkg::sdc_pins_t p);
    if (p.cs_n)
      return sdc_pkg::SDC_CMD_INHIBIT;
    unique case ({p.ras_n, p.cas_n, p.we_n})
      3'h7: return sdc_pkg::SDC_CMD_NOP;
      3'h3: return sdc_pkg::SDC_CMD_ACTIVE;
      3'h5: return sdc_pkg::SDC_CMD_READ;
      3'h4: return sdc_pkg::SDC_CMD_WRITE;
      3'h6: return sdc_pkg::SDC_CMD_TERM;
      3'h2: return sdc_pkg::SDC_CMD_PRECHARGE;
      3'h1: return p.cke ? sdc_pkg::SDC_CMD_AUTO_REF : sdc_pkg::SDC_CMD_SELF_REF;
      3'h0: return sdc_pkg::SDC_CMD_MODE_LOAD;
    endcase
  endfunction : decode

  // Start column per organisation
  function automatic logic [10:0] start_col(input logic [12:0] a, input logic [1:0] org);
    unique case (org)
      `SDC_ORG_X4:  return {a[`SDC_COL_HI_BIT], a[9:0]};
      `SDC_ORG_X8:  return {1'b0, a[9:0]};
      default:      return {2'h0, a[8:0]};
    endcase
  endfunction : start_col

  // Last beat index (length minus one) from mode length field; page = full row
  function automatic logic [10:0] burst_len(input logic [11:0] m, input logic [1:0] org);
    logic [2:0] bl;
    bl = m[`SDC_BL_MSB:`SDC_BL_LSB];
    if (bl == `SDC_BL_PAGE)
      return (org == `SDC_ORG_X4) ? 11'h7ff : (org == `SDC_ORG_X8) ? 11'h3ff : 11'h1ff;
    return (bl > 3'h3) ? 11'h000 : (11'h001 << bl) - 11'h001;
  endfunction : burst_len

  // Column of a beat: wrap within burst, sequential or interleaved
  function automatic logic [10:0] beat_col(input logic [10:0] base, input logic [9:0] beat,
                                           input logic [10:0] lmask, input logic interleave);
    logic [10:0] off;
    off = interleave ? ((base ^ {1'b0, beat}) & lmask) : ((base + {1'b0, beat}) & lmask);
    return (base & ~lmask) | off;
  endfunction : beat_col

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    sdc_pkg::sdc_cmd_t cmd;
    logic [10:0]       lmask;
    logic              last_beat;
    logic              push;
    logic              pop;
    sdc_pkg::sdc_word_t w;
    cmd       = sdc_pkg::SDC_CMD_INHIBIT;
    lmask     = 11'h000;
    last_beat = 1'b0;
    push      = 1'b0;
    pop       = 1'b0;
    w         = '0;
    nxt_st    = st_ff;
    // Two-flop capture of pins, rising edge only
    nxt_st.s1 = '{cs_n_in, ras_n_in, cas_n_in, we_n_in, cke_in,
                  {bank_select_hi_in, bank_select_lo_in}, addr_in, dqm_in, dq_in};
    nxt_st.s2 = st_ff.s1;
    nxt_st.org = org_in;
    cmd = decode(st_ff.s2);
    lmask = burst_len(st_ff.mode, st_ff.org);
    last_beat = ({1'b0, st_ff.beat} == lmask);
    // Self refresh holds until clock gate returns
    if (st_ff.bst == sdc_pkg::SDC_B_SELF)
    begin
      if (st_ff.s2.cke)
        nxt_st.bst = sdc_pkg::SDC_B_IDLE;
      cmd = sdc_pkg::SDC_CMD_INHIBIT;
    end
    // Precharge-wait countdown
    if (st_ff.pre_cnt != 4'h0)
      nxt_st.pre_cnt = st_ff.pre_cnt - 4'h1;
    // Burst engine
    unique case (st_ff.bst)
      sdc_pkg::SDC_B_BURST:
      begin
        if (st_ff.buf_vld != 2'h3 || !st_ff.is_write)
        begin
          push = 1'b1;
          nxt_st.beat = st_ff.beat + 10'h001;
          if (last_beat)
          begin
            nxt_st.bst = st_ff.auto_pre ? sdc_pkg::SDC_B_REC : sdc_pkg::SDC_B_IDLE;
            nxt_st.rec_cnt = 4'(`SDC_WR_EXTRA_CYC + 1);
          end
        end
      end
      sdc_pkg::SDC_B_REC:
      begin
        nxt_st.rec_cnt = st_ff.rec_cnt - 4'h1;
        if (st_ff.rec_cnt <= 4'h1 || !st_ff.is_write)
        begin
          nxt_st.bank_open[st_ff.bbank] = 1'b0;
          nxt_st.pre_cnt = 4'(`SDC_PRE_WAIT_CYC);
          nxt_st.bst = sdc_pkg::SDC_B_IDLE;
        end
      end
      default:
      begin
      end
    endcase
    // Word of the current beat
    w.bank = st_ff.bbank;
    w.row  = st_ff.open_rows[st_ff.bbank*13 +: 13];
    w.col  = beat_col(st_ff.start_col, st_ff.beat, lmask, st_ff.mode[`SDC_SEQ_BIT]);
    w.mask = st_ff.s2.dqm;
    w.data = st_ff.s2.wdata;
    // Command execution
    unique case (cmd)
      sdc_pkg::SDC_CMD_ACTIVE:
      begin
        nxt_st.bank_open[st_ff.s2.bank] = 1'b1;
        nxt_st.open_rows[st_ff.s2.bank*13 +: 13] = st_ff.s2.addr;
      end
      sdc_pkg::SDC_CMD_READ, sdc_pkg::SDC_CMD_WRITE:
      begin
        nxt_st.bst       = sdc_pkg::SDC_B_BURST;
        nxt_st.is_write  = (cmd == sdc_pkg::SDC_CMD_WRITE);
        nxt_st.bbank     = st_ff.s2.bank;
        nxt_st.auto_pre  = st_ff.s2.addr[`SDC_AP_BIT];
        nxt_st.start_col = start_col(st_ff.s2.addr, st_ff.org);
        nxt_st.beat      = 10'h001;
        push = 1'b1;
        nxt_st.bst = (lmask == 11'h000)
                     ? (st_ff.s2.addr[`SDC_AP_BIT] ? sdc_pkg::SDC_B_REC : sdc_pkg::SDC_B_IDLE)
                     : sdc_pkg::SDC_B_BURST;
        nxt_st.rec_cnt = 4'(`SDC_WR_EXTRA_CYC + 1);
        w.bank = st_ff.s2.bank;
        w.row  = st_ff.open_rows[st_ff.s2.bank*13 +: 13];
        w.col  = start_col(st_ff.s2.addr, st_ff.org);
      end
      sdc_pkg::SDC_CMD_TERM:
        if (st_ff.bst == sdc_pkg::SDC_B_BURST)
        begin
          nxt_st.bst = sdc_pkg::SDC_B_IDLE;
          push = 1'b0;
        end
      sdc_pkg::SDC_CMD_PRECHARGE:
      begin
        if (st_ff.s2.addr[`SDC_AP_BIT])
          nxt_st.bank_open = 4'h0;
        else
          nxt_st.bank_open[st_ff.s2.bank] = 1'b0;
        nxt_st.pre_cnt = 4'(`SDC_PRE_WAIT_CYC);
        if (st_ff.bst == sdc_pkg::SDC_B_BURST)
          nxt_st.bst = sdc_pkg::SDC_B_IDLE;
      end
      sdc_pkg::SDC_CMD_AUTO_REF:
        nxt_st.ref_row = st_ff.ref_row + 13'h0001;
      sdc_pkg::SDC_CMD_SELF_REF:
      begin
        nxt_st.ref_row = st_ff.ref_row + 13'h0001;
        nxt_st.bst = sdc_pkg::SDC_B_SELF;
      end
      sdc_pkg::SDC_CMD_MODE_LOAD:
        nxt_st.mode = st_ff.s2.addr[11:0];
      default:
      begin
      end
    endcase
    // Two-entry buffer toward the array, writes stall on full
    w.mask = (nxt_st.is_write || cmd == sdc_pkg::SDC_CMD_WRITE) ? w.mask : 2'h0;
    pop = st_ff.buf_vld[0] && arr_ready_in;
    if (pop)
    begin
      nxt_st.buf0 = st_ff.buf1;
      nxt_st.buf_vld = {1'b0, st_ff.buf_vld[1]};
    end
    if (push && nxt_st.buf_vld != 2'h3)
    begin
      if (!nxt_st.buf_vld[0])
      begin
        nxt_st.buf0 = w;
        nxt_st.buf_vld[0] = 1'b1;
      end
      else
      begin
        nxt_st.buf1 = w;
        nxt_st.buf_vld[1] = 1'b1;
      end
    end
    nxt_st.wr_valid = nxt_st.buf_vld[0];
    nxt_st.wr_word  = nxt_st.buf0;
    // Ready flag registered so the status pin comes from a flop
    nxt_st.cmd_rdy  = (nxt_st.bst == sdc_pkg::SDC_B_IDLE) && (nxt_st.pre_cnt == 4'h0);
    // Read data path: mask registered two clocks before the data
    nxt_st.rd_act_d1 = pop && !st_ff.is_write;
    nxt_st.rd_act_d2 = st_ff.rd_act_d1;
    nxt_st.dqm_d1    = st_ff.s2.dqm;
    nxt_st.dqm_d2    = st_ff.dqm_d1;
    nxt_st.rd_q      = arr_rdata_in;
    nxt_st.dq_out    = st_ff.rd_q;
    nxt_st.dq_oe     = st_ff.rd_act_d2 ? ~st_ff.dqm_d2 : 2'h0;
    nxt_st.bank_idle_o = 2'h0;
    nxt_st.self_ref  = (nxt_st.bst == sdc_pkg::SDC_B_SELF);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_ff      <= '0;
      st_ff.s1   <= '{cs_n: 1'b1, default: '0};
      st_ff.s2   <= '{cs_n: 1'b1, default: '0};
      st_ff.mode <= `SDC_MODE_RESET;
      st_ff.bst  <= sdc_pkg::SDC_B_IDLE;
    end
    else
      st_ff <= nxt_st;
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign dq_out           = st_ff.dq_out;
  assign dq_oe_out        = st_ff.dq_oe;
  assign arr_valid_out    = st_ff.buf_vld[0];
  assign arr_write_out    = st_ff.is_write;
  assign arr_bank_out     = st_ff.buf0.bank;
  assign arr_row_out      = st_ff.buf0.row;
  assign arr_col_out      = st_ff.buf0.col;
  assign arr_mask_out     = st_ff.buf0.mask;
  assign arr_wdata_out    = st_ff.buf0.data;
  assign bank_open_out    = st_ff.bank_open;
  assign mode_out         = st_ff.mode;
  assign self_refresh_out = st_ff.self_ref;
  assign cmd_ready_out    = st_ff.cmd_rdy;

endmodule : sdc_core

// [sdc_core_chk.sv]
// Concurrent checks on the command pins and outputs of sdc_core
// Bound to every sdc_core instance at the foot of this file; one clock domain
`timescale 1ns/10ps
module sdc_core_chk (
  // Clock, reset and command pins
  input wire logic        ref_clk_in,
  input wire logic        rst_in,
  input wire logic        cs_n_in,
  input wire logic        ras_n_in,
  input wire logic        cas_n_in,
  input wire logic        we_n_in,
  input wire logic        cke_in,
  input wire logic        bank_select_lo_in,
  input wire logic        bank_select_hi_in,
  input wire logic [12:0] addr_in,
  input wire logic [1:0]  dqm_in,
  // Watched outputs
  input wire logic [1:0]  dq_oe_out,
  input wire logic        arr_valid_out,
  input wire logic        arr_write_out,
  input wire logic [10:0] arr_col_out,
  input wire logic [1:0]  arr_mask_out,
  input wire logic [15:0] arr_wdata_out,
  input wire logic        arr_ready_in,
  input wire logic [3:0]  bank_open_out,
  input wire logic [11:0] mode_out,
  input wire logic        self_refresh_out
);
  logic [3:0]  pc;
  logic [1:0]  cmd_b_ff;
  logic [11:0] op_ff;
  logic [4:0]  act_sr_ff;

  // Strobes as one code, chip select first
  assign pc = {cs_n_in, ras_n_in, cas_n_in, we_n_in};

  // Bank of the last command, opcode of the last mode load, history of activates
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cmd_b_ff  <= 2'h0;
      op_ff     <= 12'h000;
      act_sr_ff <= 5'h00;
    end
    else
    begin
      act_sr_ff <= {act_sr_ff[3:0], (pc == 4'h3) && cke_in};
      if (!cs_n_in && (pc != 4'h7))
        cmd_b_ff <= {bank_select_hi_in, bank_select_lo_in};
      if (pc == 4'h0)
        op_ff <= addr_in[11:0];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  a_reset_clear: assert property (@(posedge ref_clk_in) disable iff (1'b0)
    rst_in |-> (bank_open_out == 4'h0) && !arr_valid_out && (mode_out == 12'h000))
    else $error("outputs not clear in reset");
  a_act_opens: assert property (
    (pc == 4'h3) && cke_in |-> ##[2:5] bank_open_out[cmd_b_ff])
    else $error("activated bank not open");
  a_open_cause: assert property (
    |(bank_open_out & ~$past(bank_open_out)) |-> |act_sr_ff)
    else $error("bank opened without activate");
  a_pre_one: assert property (
    (pc == 4'h2) && !addr_in[10] && cke_in |-> ##[2:6] !bank_open_out[cmd_b_ff])
    else $error("precharged bank still open");
  a_pre_all: assert property (
    (pc == 4'h2) && addr_in[10] && cke_in |-> ##[2:6] (bank_open_out == 4'h0))
    else $error("banks open after precharge all");
  a_mode_load: assert property (
    (pc == 4'h0) && cke_in |-> ##[2:5] (mode_out == op_ff))
    else $error("mode register not loaded");
  a_self_entry: assert property (
    (pc == 4'h1) && !cke_in |-> ##[2:5] self_refresh_out)
    else $error("self refresh not entered");
  a_self_freeze: assert property (
    self_refresh_out && !cke_in |=> $stable(bank_open_out) && $stable(mode_out))
    else $error("state changed in self refresh");
  a_word_holds: assert property (
    arr_valid_out && !arr_ready_in |=> arr_valid_out
      && $stable({arr_write_out, arr_col_out, arr_mask_out, arr_wdata_out}))
    else $error("array word changed while stalled");
  a_write_word: assert property (
    (pc == 4'h4) && cke_in && !self_refresh_out |-> ##[2:6] arr_valid_out && arr_write_out)
    else $error("write produced no array word");
  a_read_mask: assert property (
    |dq_oe_out |-> (dq_oe_out & $past(dqm_in, 2) & $past(dqm_in, 3)
      & $past(dqm_in, 4) & $past(dqm_in, 5)) == 2'h0)
    else $error("masked byte driven on read");
endmodule : sdc_core_chk

bind sdc_core sdc_core_chk i_chk (
  .ref_clk_in, .rst_in, .cs_n_in, .ras_n_in, .cas_n_in, .we_n_in, .cke_in,
  .bank_select_lo_in, .bank_select_hi_in, .addr_in, .dqm_in, .dq_oe_out,
  .arr_valid_out, .arr_write_out, .arr_col_out, .arr_mask_out, .arr_wdata_out,
  .arr_ready_in, .bank_open_out, .mode_out, .self_refresh_out
);

// [sdc_ctrl_model.sv]
// Memory controller model driving the command pins of sdc_core
// Assumes the bench clock; commands are issued through its tasks only
`timescale 1ns/10ps
module sdc_ctrl_model #(
  parameter int PAUSE_CYC = 20
) (
  // Clock
  input  wire logic   ref_clk_in,
  // Command pins, cmd_out is {cs_n, ras_n, cas_n, we_n}
  output logic [3:0]  cmd_out,
  output logic        cke_out,
  output logic [1:0]  bank_out,
  output logic [12:0] addr_out,
  output logic [1:0]  dqm_out,
  output logic [15:0] dq_out
);
  // Deselected until the first command
  initial
  begin
    cmd_out  = 4'hf;
    cke_out  = 1'b1;
    bank_out = 2'h0;
    addr_out = 13'h0000;
    dqm_out  = 2'h0;
    dq_out   = 16'h0000;
  end

  // Command edge, NOP with second data beat and inverted bank/address, then inverted data and a wait tail
  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
                     input logic [1:0] m, input logic [15:0] d, input logic [15:0] d2);
    @(posedge ref_clk_in);
    cmd_out  <= c;
    bank_out <= b;
    addr_out <= a;
    dqm_out  <= m;
    dq_out   <= d;
    @(posedge ref_clk_in);
    cmd_out  <= 4'h7;
    bank_out <= ~b;
    addr_out <= ~a;
    dq_out   <= d2;
    @(posedge ref_clk_in);
    dq_out   <= ~d2;
    repeat (3) @(posedge ref_clk_in);
  endtask : cmd

  // Clock gate changes only between commands
  task automatic set_cke(input logic v);
    @(posedge ref_clk_in);
    cke_out <= v;
  endtask : set_cke

  // Power-up pause, then two auto refreshes
  task automatic init();
    repeat (PAUSE_CYC) @(posedge ref_clk_in);
    cmd(4'h1, 2'h0, 13'h0000, 2'h0, 16'h0000, 16'hffff);
    cmd(4'h1, 2'h0, 13'h0000, 2'h0, 16'h0000, 16'hffff);
  endtask : init
endmodule : sdc_ctrl_model

// [sdc_pkg.sv]
// Types for the synchronous DRAM command decoder
// Constants live in sdc_cfg.svh
package sdc_pkg;

  // ----------------------------------------------------------------
  // Commands
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SDC_CMD_INHIBIT, SDC_CMD_NOP, SDC_CMD_ACTIVE, SDC_CMD_READ, SDC_CMD_WRITE,
    SDC_CMD_TERM, SDC_CMD_PRECHARGE, SDC_CMD_AUTO_REF, SDC_CMD_SELF_REF,
    SDC_CMD_MODE_LOAD
  } sdc_cmd_t;

  // Burst engine states, Gray along idle-read/write-recovery path
  typedef enum logic [1:0] {
    SDC_B_IDLE  = 2'h0,
    SDC_B_BURST = 2'h1,
    SDC_B_REC   = 2'h3,
    SDC_B_SELF  = 2'h2
  } sdc_burst_st_t;

  // Command pins as sampled
  typedef struct packed {
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic        cke;
    logic [1:0]  bank;
    logic [12:0] addr;
    logic [1:0]  dqm;
    logic [15:0] wdata;
  } sdc_pins_t;

  // One array write or read word
  typedef struct packed {
    logic [1:0]  bank;
    logic [12:0] row;
    logic [10:0] col;
    logic [1:0]  mask;
    logic [15:0] data;
  } sdc_word_t;

  // Whole state of the core
  typedef struct packed {
    sdc_pins_t     s1;
    sdc_pins_t     s2;
    logic [3:0]    bank_open;
    logic [51:0]   open_rows;
    logic [11:0]   mode;
    logic [12:0]   ref_row;
    sdc_burst_st_t bst;
    logic          is_write;
    logic          auto_pre;
    logic [1:0]    bbank;
    logic [10:0]   start_col;
    logic [9:0]    beat;
    logic [3:0]    rec_cnt;
    logic [3:0]    pre_cnt;
    sdc_word_t     buf0;
    sdc_word_t     buf1;
    logic [1:0]    buf_vld;
    logic [1:0]    dqm_d1;
    logic [1:0]    dqm_d2;
    logic          rd_act_d1;
    logic          rd_act_d2;
    logic [15:0]   rd_q;
    logic [15:0]   dq_out;
    logic [1:0]    dq_oe;
    logic          wr_valid;
    sdc_word_t     wr_word;
    logic [1:0]    bank_idle_o;
    logic          self_ref;
    logic [1:0]    org;
    logic          cmd_rdy;
  } sdc_state_t;

endpackage : sdc_pkg
